// ### logic/loop_ctrl_pkg.sv
package loop_ctrl_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [9:0] OFS_LOOP_ENABLE_CTRL = 10'h191;
   localparam logic [9:0] OFS_LOOP_INTEGER_AND_UPDATE = 10'h192;
   localparam logic [9:0] OFS_LOOP_FRAC_NUMERATOR = 10'h193;
   localparam logic [9:0] OFS_LOOP_FRAC_DENOMINATOR = 10'h194;
   localparam logic [9:0] OFS_LOOP_DIVIDER_CTRL = 10'h195;
   localparam logic [9:0] OFS_LOOP_REFERENCE_SELECT = 10'h196;
   localparam logic [9:0] OFS_LOOP_GAIN_CTRL = 10'h199;
   localparam logic [9:0] OFS_SYNC_ENABLE_CTRL = 10'h1A1;
   localparam logic [9:0] OFS_SYNC_INTEGER = 10'h1A2;
   localparam logic [9:0] OFS_SYNC_FRAC_NUMERATOR = 10'h1A3;
   localparam logic [9:0] OFS_SYNC_FRAC_DENOMINATOR = 10'h1A4;
   localparam logic [9:0] OFS_SYNC_VCO_RATIO = 10'h1A5;
   localparam logic [9:0] OFS_SYNC_REFERENCE_SELECT = 10'h1A6;
   localparam logic [9:0] OFS_SYNC_GAIN_BANDWIDTH = 10'h1A7;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int POS_ENABLE = 0;
   localparam int POS_UPDATE = 15;
   localparam int POS_OSC_RATIO = 8;
   localparam int POS_OUT_DIV = 1;
   localparam int POS_PREDIV = 6;
   localparam int POS_REF_SEL = 0;
   localparam int POS_GAIN = 2;
   localparam int POS_BANDWIDTH = 0;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [9:0] RST_LOOP_INT = 10'h008;
   localparam logic [15:0] RST_LOOP_NUM = 16'h0018;
   localparam logic [15:0] RST_LOOP_DEN = 16'h007D;
   localparam logic [3:0] RST_LOOP_OSC_RATIO = 4'h0;
   localparam logic [2:0] RST_LOOP_OUT_DIV = 3'h6;
   localparam logic [1:0] RST_PREDIV = 2'h0;
   localparam logic [3:0] RST_REF_SEL = 4'h0;
   localparam logic [3:0] RST_GAIN = 4'h0;
   localparam logic [9:0] RST_SYNC_INT = 10'h000;
   localparam logic [15:0] RST_SYNC_FRAC = 16'h0000;
   localparam logic [2:0] RST_SYNC_OSC_RATIO = 3'h0;
   localparam logic RST_BANDWIDTH = 1'b1;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic enable;
      logic [9:0] int_mult;
      logic [15:0] frac_num;
      logic [15:0] frac_den;
      logic [4:0] osc_div;
      logic [2:0] out_div;
      logic out_div_valid;
      logic [3:0] prediv;
      logic [3:0] ref_select;
      logic ref_valid;
      logic [8:0] gain;
   } loop_cfg_t;

   typedef struct packed {
      logic enable;
      logic [9:0] int_mult;
      logic [15:0] frac_num;
      logic [15:0] frac_den;
      logic [4:0] osc_div;
      logic [3:0] prediv;
      logic [3:0] ref_select;
      logic ref_valid;
      logic [8:0] gain;
      logic narrow_bw;
   } sync_cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } loop_state_t;

endpackage

// ### logic/second_freq_loop_ctrl_regs.sv
`timescale 1ns/1ns
// Contract
// - writing one to update bit 15 commits pending multipliers, only while enabled.
// - integer multiplier bits 9:0, reset 008h, deferred while enabled until update.
// - fractional numerator 16 bits, reset 0018h, deferred while enabled until update.
// - fractional denominator 16 bits, reset 007Dh, sets fractional ratio with numerator.
// - oscillator divider bits 11:8 divides by code plus one.
// - output divider bits 3:1 divides by 2 to 7, codes 0 and 1 reserved, reset 110.
// - reference pre-divider bits 7:6 divides by 1, 2, 4 or 8.
// - reference source bits 3:0 picks pins, loops, bit clocks or frame clocks.
// - loop gain bits 5:2 is two to the code, 256 for codes 8 and up.
// - synchroniser integer multiplier bits 9:0, reset 000h.
// - synchroniser numerator and denominator 16 bits each, reset 0000h.
// - synchroniser oscillator divider bits 10:8: 1,2,4,8, top bit set gives 16.
// - synchroniser pre-divider bits 7:6 divides by 1, 2, 4 or 8.
// - synchroniser source same codes as main, but 1010 reserved.
// - synchroniser gain bits 5:2 is two to the code, 256 for 8 and up.
// - synchroniser bandwidth bit 0: zero wide, one narrow, reset one.
module second_freq_loop_ctrl_regs (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // register port
   input wire logic [9:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // decoded configuration
   output loop_ctrl_pkg::loop_cfg_t loop_cfg,
   output loop_ctrl_pkg::sync_cfg_t sync_cfg,
   output logic loop_running
);

   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic [8:0] gain_of(input logic [3:0] code);
      gain_of = code[3] ? 9'h100 : (9'h001 << code[2:0]);
   endfunction

   function automatic logic [3:0] prediv_of(input logic [1:0] code);
      prediv_of = 4'h1 << code;
   endfunction

   function automatic logic src_ok(input logic [3:0] code, input logic sync);
      case (code)
         4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE: src_ok = 1'b1;
         4'hA: src_ok = !sync;
         default: src_ok = 1'b0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic loop_en_q;
   logic [9:0] int_pend_q;
   logic [15:0] num_pend_q;
   logic [9:0] int_act_q;
   logic [15:0] num_act_q;
   logic [15:0] den_q;
   logic [3:0] osc_ratio_q;
   logic [2:0] out_div_q;
   logic [1:0] prediv_q;
   logic [3:0] ref_sel_q;
   logic [3:0] gain_q;
   logic sync_en_q;
   logic [9:0] sync_int_q;
   logic [15:0] sync_num_q;
   logic [15:0] sync_den_q;
   logic [2:0] sync_osc_q;
   logic [1:0] sync_prediv_q;
   logic [3:0] sync_ref_q;
   logic [3:0] sync_gain_q;
   logic sync_bw_q;
   logic [15:0] rdata_q;
   loop_ctrl_pkg::loop_state_t state_q;
   loop_ctrl_pkg::loop_state_t state_d;
   loop_ctrl_pkg::loop_cfg_t loop_cfg_q;
   loop_ctrl_pkg::sync_cfg_t sync_cfg_q;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire logic wr = reg_wr && clk_en;
   wire logic wr_en = wr && (reg_addr == loop_ctrl_pkg::OFS_LOOP_ENABLE_CTRL);
   wire logic wr_int = wr && (reg_addr == loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE);
   wire logic wr_num = wr && (reg_addr == loop_ctrl_pkg::OFS_LOOP_FRAC_NUMERATOR);
   wire logic wr_den = wr && (reg_addr == loop_ctrl_pkg::OFS_LOOP_FRAC_DENOMINATOR);
   wire logic wr_div = wr && (reg_addr == loop_ctrl_pkg::OFS_LOOP_DIVIDER_CTRL);
   wire logic wr_ref = wr && (reg_addr == loop_ctrl_pkg::OFS_LOOP_REFERENCE_SELECT);
   wire logic wr_gain = wr && (reg_addr == loop_ctrl_pkg::OFS_LOOP_GAIN_CTRL);
   wire logic wr_sen = wr && (reg_addr == loop_ctrl_pkg::OFS_SYNC_ENABLE_CTRL);
   wire logic wr_sint = wr && (reg_addr == loop_ctrl_pkg::OFS_SYNC_INTEGER);
   wire logic wr_snum = wr && (reg_addr == loop_ctrl_pkg::OFS_SYNC_FRAC_NUMERATOR);
   wire logic wr_sden = wr && (reg_addr == loop_ctrl_pkg::OFS_SYNC_FRAC_DENOMINATOR);
   wire logic wr_sosc = wr && (reg_addr == loop_ctrl_pkg::OFS_SYNC_VCO_RATIO);
   wire logic wr_sref = wr && (reg_addr == loop_ctrl_pkg::OFS_SYNC_REFERENCE_SELECT);
   wire logic wr_sgain = wr && (reg_addr == loop_ctrl_pkg::OFS_SYNC_GAIN_BANDWIDTH);

   // update strobe acts only while the loop is enabled
   wire logic upd = wr_int && reg_wdata[loop_ctrl_pkg::POS_UPDATE] && loop_en_q;
   // while the loop is disabled, pending values pass straight through
   wire logic int_direct = wr_int && !loop_en_q;
   wire logic num_direct = wr_num && !loop_en_q;

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   logic [15:0] rmux;
   always_comb begin
      rmux = 16'h0000;
      case (reg_addr)
         loop_ctrl_pkg::OFS_LOOP_ENABLE_CTRL: rmux = {15'h0000, loop_en_q};
         loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE: rmux = {6'h00, int_pend_q};
         loop_ctrl_pkg::OFS_LOOP_FRAC_NUMERATOR: rmux = num_pend_q;
         loop_ctrl_pkg::OFS_LOOP_FRAC_DENOMINATOR: rmux = den_q;
         loop_ctrl_pkg::OFS_LOOP_DIVIDER_CTRL: rmux = {4'h0, osc_ratio_q, 4'h0, out_div_q, 1'b0};
         loop_ctrl_pkg::OFS_LOOP_REFERENCE_SELECT: rmux = {8'h00, prediv_q, 2'h0, ref_sel_q};
         loop_ctrl_pkg::OFS_LOOP_GAIN_CTRL: rmux = {10'h000, gain_q, 2'h0};
         loop_ctrl_pkg::OFS_SYNC_ENABLE_CTRL: rmux = {15'h0000, sync_en_q};
         loop_ctrl_pkg::OFS_SYNC_INTEGER: rmux = {6'h00, sync_int_q};
         loop_ctrl_pkg::OFS_SYNC_FRAC_NUMERATOR: rmux = sync_num_q;
         loop_ctrl_pkg::OFS_SYNC_FRAC_DENOMINATOR: rmux = sync_den_q;
         loop_ctrl_pkg::OFS_SYNC_VCO_RATIO: rmux = {5'h00, sync_osc_q, 8'h00};
         loop_ctrl_pkg::OFS_SYNC_REFERENCE_SELECT: rmux = {8'h00, sync_prediv_q, 2'h0, sync_ref_q};
         loop_ctrl_pkg::OFS_SYNC_GAIN_BANDWIDTH: rmux = {10'h000, sync_gain_q, 1'b0, sync_bw_q};
         default: rmux = 16'h0000;
      endcase
   end

   // ---------------------------------------------------------------
   // loop state
   // ---------------------------------------------------------------
   always_comb begin
      case (state_q)
         loop_ctrl_pkg::ST_IDLE: state_d = loop_en_q ? loop_ctrl_pkg::ST_RUN : loop_ctrl_pkg::ST_IDLE;
         loop_ctrl_pkg::ST_RUN: state_d = loop_en_q ? loop_ctrl_pkg::ST_RUN : loop_ctrl_pkg::ST_IDLE;
         default: state_d = loop_ctrl_pkg::ST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // main loop registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loop_en_q <= 1'b0;
         int_pend_q <= loop_ctrl_pkg::RST_LOOP_INT;
         num_pend_q <= loop_ctrl_pkg::RST_LOOP_NUM;
         den_q <= loop_ctrl_pkg::RST_LOOP_DEN;
         osc_ratio_q <= loop_ctrl_pkg::RST_LOOP_OSC_RATIO;
         out_div_q <= loop_ctrl_pkg::RST_LOOP_OUT_DIV;
         prediv_q <= loop_ctrl_pkg::RST_PREDIV;
         ref_sel_q <= loop_ctrl_pkg::RST_REF_SEL;
         gain_q <= loop_ctrl_pkg::RST_GAIN;
         state_q <= loop_ctrl_pkg::ST_IDLE;
      end else if (clk_en) begin
         state_q <= state_d;
         if (wr_en) loop_en_q <= reg_wdata[loop_ctrl_pkg::POS_ENABLE];
         if (wr_int) int_pend_q <= reg_wdata[9:0];
         if (wr_num) num_pend_q <= reg_wdata;
         if (wr_den) den_q <= reg_wdata;
         if (wr_div) begin
            osc_ratio_q <= reg_wdata[loop_ctrl_pkg::POS_OSC_RATIO +: 4];
            out_div_q <= reg_wdata[loop_ctrl_pkg::POS_OUT_DIV +: 3];
         end
         if (wr_ref) begin
            prediv_q <= reg_wdata[loop_ctrl_pkg::POS_PREDIV +: 2];
            ref_sel_q <= reg_wdata[loop_ctrl_pkg::POS_REF_SEL +: 4];
         end
         if (wr_gain) gain_q <= reg_wdata[loop_ctrl_pkg::POS_GAIN +: 4];
      end
   end

   // active multipliers: follow writes while disabled, commit on update while enabled
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         int_act_q <= loop_ctrl_pkg::RST_LOOP_INT;
         num_act_q <= loop_ctrl_pkg::RST_LOOP_NUM;
      end else if (clk_en) begin
         if (upd) begin
            int_act_q <= int_pend_q;
            num_act_q <= num_pend_q;
         end
         if (int_direct) int_act_q <= reg_wdata[9:0];
         if (num_direct) num_act_q <= reg_wdata;
      end
   end

   // ---------------------------------------------------------------
   // synchroniser registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_en_q <= 1'b0;
         sync_int_q <= loop_ctrl_pkg::RST_SYNC_INT;
         sync_num_q <= loop_ctrl_pkg::RST_SYNC_FRAC;
         sync_den_q <= loop_ctrl_pkg::RST_SYNC_FRAC;
         sync_osc_q <= loop_ctrl_pkg::RST_SYNC_OSC_RATIO;
         sync_prediv_q <= loop_ctrl_pkg::RST_PREDIV;
         sync_ref_q <= loop_ctrl_pkg::RST_REF_SEL;
         sync_gain_q <= loop_ctrl_pkg::RST_GAIN;
         sync_bw_q <= loop_ctrl_pkg::RST_BANDWIDTH;
      end else if (clk_en) begin
         if (wr_sen) sync_en_q <= reg_wdata[loop_ctrl_pkg::POS_ENABLE];
         if (wr_sint) sync_int_q <= reg_wdata[9:0];
         if (wr_snum) sync_num_q <= reg_wdata;
         if (wr_sden) sync_den_q <= reg_wdata;
         if (wr_sosc) sync_osc_q <= reg_wdata[loop_ctrl_pkg::POS_OSC_RATIO +: 3];
         if (wr_sref) begin
            sync_prediv_q <= reg_wdata[loop_ctrl_pkg::POS_PREDIV +: 2];
            sync_ref_q <= reg_wdata[loop_ctrl_pkg::POS_REF_SEL +: 4];
         end
         if (wr_sgain) begin
            sync_gain_q <= reg_wdata[loop_ctrl_pkg::POS_GAIN +: 4];
            sync_bw_q <= reg_wdata[loop_ctrl_pkg::POS_BANDWIDTH];
         end
      end
   end

   // ---------------------------------------------------------------
   // decoded outputs and read data
   // ---------------------------------------------------------------
   loop_ctrl_pkg::loop_cfg_t loop_cfg_d;
   loop_ctrl_pkg::sync_cfg_t sync_cfg_d;
   always_comb begin
      loop_cfg_d.enable = loop_en_q;
      loop_cfg_d.int_mult = int_act_q;
      loop_cfg_d.frac_num = num_act_q;
      loop_cfg_d.frac_den = den_q;
      loop_cfg_d.osc_div = {1'b0, osc_ratio_q} + 5'h01;
      loop_cfg_d.out_div = out_div_q;
      loop_cfg_d.out_div_valid = (out_div_q[2:1] != 2'h0);
      loop_cfg_d.prediv = prediv_of(prediv_q);
      loop_cfg_d.ref_select = ref_sel_q;
      loop_cfg_d.ref_valid = src_ok(ref_sel_q, 1'b0);
      loop_cfg_d.gain = gain_of(gain_q);
      sync_cfg_d.enable = sync_en_q;
      sync_cfg_d.int_mult = sync_int_q;
      sync_cfg_d.frac_num = sync_num_q;
      sync_cfg_d.frac_den = sync_den_q;
      sync_cfg_d.osc_div = sync_osc_q[2] ? 5'h10 : (5'h01 << sync_osc_q[1:0]);
      sync_cfg_d.prediv = prediv_of(sync_prediv_q);
      sync_cfg_d.ref_select = sync_ref_q;
      sync_cfg_d.ref_valid = src_ok(sync_ref_q, 1'b1);
      sync_cfg_d.gain = gain_of(sync_gain_q);
      sync_cfg_d.narrow_bw = sync_bw_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loop_cfg_q <= '0;
         sync_cfg_q <= '0;
         rdata_q <= 16'h0000;
      end else if (clk_en) begin
         loop_cfg_q <= loop_cfg_d;
         sync_cfg_q <= sync_cfg_d;
         rdata_q <= reg_rd ? rmux : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;
   assign loop_cfg = loop_cfg_q;
   assign sync_cfg = sync_cfg_q;
   assign loop_running = state_q[1];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_UPD_COMMIT: assert property (@(posedge clk) disable iff (!rst_n)
      upd |=> (int_act_q == $past(int_pend_q)) && (num_act_q == $past(num_pend_q)))
      else $error("update did not commit pending values");

   AST_INT_HELD: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && loop_en_q && !upd) |=> $stable(int_act_q))
      else $error("integer multiplier changed without update");

   AST_NUM_HELD: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && loop_en_q && !upd) |=> $stable(num_act_q))
      else $error("numerator changed without update");

   AST_DEN_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      wr_den |=> ##1 loop_cfg.frac_den == $past(reg_wdata, 2))
      else $error("denominator not applied");

   AST_OSC_DIV: assert property (@(posedge clk) disable iff (!rst_n)
      (rst_n && clk_en) |=> loop_cfg.osc_div == {1'b0, $past(osc_ratio_q)} + 5'h01)
      else $error("oscillator divider wrong");

   AST_OUT_VALID: assert property (@(posedge clk) disable iff (!rst_n)
      (rst_n && clk_en) |=> loop_cfg.out_div_valid == ($past(out_div_q) >= 3'h2))
      else $error("output divider validity wrong");

   AST_GAIN_SAT: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && gain_q[3]) |=> loop_cfg.gain == 9'h100)
      else $error("loop gain not saturated");

   AST_SYNC_OSC: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && sync_osc_q[2]) |=> sync_cfg.osc_div == 5'h10)
      else $error("sync divider not sixteen");

   AST_SYNC_SRC: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && sync_ref_q == 4'hA) |=> !sync_cfg.ref_valid)
      else $error("sync source 1010 accepted");

   AST_UPD_READ: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE) |=> !reg_rdata[15])
      else $error("update bit read back as one");

   AST_SYNC_BW: assert property (
      (rst_n && clk_en) |=> sync_cfg.narrow_bw == $past(sync_bw_q))
      else $error("bandwidth wrong");

   AST_PREDIV: assert property (
      (rst_n && clk_en) |=> loop_cfg.prediv == 4'h1 << $past(prediv_q))
      else $error("prediv wrong");

   AST_SYNC_PREDIV: assert property (
      (rst_n && clk_en) |=> sync_cfg.prediv == 4'h1 << $past(sync_prediv_q))
      else $error("sync prediv wrong");

   AST_GAIN_LOW: assert property (
      (rst_n && clk_en && !gain_q[3]) |=> loop_cfg.gain == 9'h001 << $past(gain_q[2:0]))
      else $error("gain wrong");

   AST_SYNC_GAIN: assert property (
      (rst_n && clk_en && sync_gain_q[3]) |=> sync_cfg.gain == 9'h100)
      else $error("sync gain not saturated");

   AST_REF_IFACE: assert property (
      (rst_n && clk_en && ref_sel_q == 4'hA) |=> loop_cfg.ref_valid)
      else $error("source 1010 refused");

   AST_SYNC_REF_OK: assert property (
      (rst_n && clk_en && sync_ref_q == 4'hE) |=> sync_cfg.ref_valid)
      else $error("sync source refused");

   AST_SYNC_INT: assert property (
      (rst_n && wr_sint) |=> sync_int_q == $past(reg_wdata[9:0]))
      else $error("sync int not stored");

   AST_SYNC_NUM: assert property (
      (rst_n && wr_snum) |=> sync_num_q == $past(reg_wdata))
      else $error("sync num not stored");

   AST_INT_DIRECT: assert property (
      (rst_n && int_direct) |=> int_act_q == $past(reg_wdata[9:0]))
      else $error("idle int not applied");

   AST_NUM_DIRECT: assert property (
      (rst_n && num_direct) |=> num_act_q == $past(reg_wdata))
      else $error("idle num not applied");

   AST_SYNC_OSC_LOW: assert property (
      (rst_n && clk_en && !sync_osc_q[2]) |=> sync_cfg.osc_div == 5'h01 << $past(sync_osc_q[1:0]))
      else $error("sync divider wrong");

   AST_OUT_DIV: assert property (
      (rst_n && clk_en) |=> loop_cfg.out_div == $past(out_div_q))
      else $error("out div wrong");

endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk;
   logic rst_n;
   logic clk_en;
   logic [9:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   loop_ctrl_pkg::loop_cfg_t loop_cfg;
   loop_ctrl_pkg::sync_cfg_t sync_cfg;
   logic loop_running;
   int err_count = 0;
   int check_count = 0;
   int cyc_q = 0;
   logic [31:0] rng_q = 32'hBC1564C0;
   logic [15:0] a2, n2, r;
   logic [3:0] c;
   logic [9:0] map_addr [14] = '{10'h191, 10'h192, 10'h193, 10'h194, 10'h195, 10'h196, 10'h199,
      10'h1A1, 10'h1A2, 10'h1A3, 10'h1A4, 10'h1A5, 10'h1A6, 10'h1A7};
   logic [15:0] map_mask [14] = '{16'h0001, 16'h03FF, 16'hFFFF, 16'hFFFF, 16'h0F0E, 16'h00CF, 16'h003C,
      16'h0001, 16'h03FF, 16'hFFFF, 16'hFFFF, 16'h0700, 16'h00CF, 16'h003D};
   logic [15:0] map_dflt [14] = '{16'h0000, 16'h0008, 16'h0018, 16'h007D, 16'h000C, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001};

   second_freq_loop_ctrl_regs dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .loop_cfg(loop_cfg), .sync_cfg(sync_cfg), .loop_running(loop_running));

   // ---------------------------------------------------------------
   // clock and timeout
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc_q <= cyc_q + 1;
      if (cyc_q == 20000) begin
         err_count++;
         summarize();
      end
   end

   // ---------------------------------------------------------------
   // expectation helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] xs();
      logic [31:0] s;
      s = rng_q;
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      rng_q = s;
      return s[31:16];
   endfunction

   function automatic logic [15:0] f_gain(input logic [3:0] k);
      return k[3] ? 16'h0100 : (16'h0001 << k[2:0]);
   endfunction

   function automatic logic [15:0] f_sosc(input logic [2:0] k);
      return k[2] ? 16'h0010 : (16'h0001 << k[1:0]);
   endfunction

   function automatic logic [15:0] f_ref_ok(input logic [3:0] k, input logic sync);
      logic ok;
      ok = (k inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE}) && !(sync && k == 4'hA);
      return {15'h0000, ok};
   endfunction

   // ---------------------------------------------------------------
   // bus tasks and compare
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
   endtask

   task automatic rd(input logic [9:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e, "read data");
   endtask

   task automatic settle();
      repeat (3) begin
         @(posedge clk);
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
      end
      #1;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check_defaults();
      wr(10'h197, xs());
      wr(10'h19A, xs());
      for (int i = 0; i < 14; i++) rd(map_addr[i], map_dflt[i]);
      rd(10'h197, 16'h0000);
      settle();
      chk(16'(loop_cfg.int_mult), 16'h0008, "int reset");
      chk(loop_cfg.frac_num, 16'h0018, "num reset");
      chk(loop_cfg.frac_den, 16'h007D, "den reset");
      chk(16'(loop_cfg.out_div), 16'h0006, "outdiv reset");
      chk(16'(loop_cfg.osc_div), 16'h0001, "osc reset");
      chk(16'(sync_cfg.narrow_bw), 16'h0001, "bw reset");
      chk(16'({loop_cfg.enable, sync_cfg.enable, loop_running}), 16'h0000, "enables reset");
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      reg_addr = 10'h000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      do_reset();
      check_defaults();
      end_test("defaults");
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         r = xs();
         wr(loop_ctrl_pkg::OFS_LOOP_DIVIDER_CTRL, (r & ~16'h0F0E) | (16'(c) << 8) | (16'(c[2:0]) << 1));
         wr(loop_ctrl_pkg::OFS_SYNC_VCO_RATIO, (r & ~16'h0700) | (16'(c[2:0]) << 8));
         wr(loop_ctrl_pkg::OFS_LOOP_REFERENCE_SELECT, (r & ~16'h00CF) | (16'(c[1:0]) << 6) | 16'(c));
         wr(loop_ctrl_pkg::OFS_SYNC_REFERENCE_SELECT, (r & ~16'h00CF) | (16'(c[1:0]) << 6) | 16'(c));
         wr(loop_ctrl_pkg::OFS_LOOP_GAIN_CTRL, (r & ~16'h003C) | (16'(c) << 2));
         wr(loop_ctrl_pkg::OFS_SYNC_GAIN_BANDWIDTH, (r & ~16'h003D) | (16'(c) << 2) | 16'(c[0]));
         settle();
         chk(16'(loop_cfg.osc_div), 16'(c) + 16'h0001, "osc div");
         chk(16'(loop_cfg.out_div), 16'(c[2:0]), "out div");
         chk(16'(loop_cfg.out_div_valid), 16'(c[2:1] != 2'b00), "out div valid");
         chk(16'(sync_cfg.osc_div), f_sosc(c[2:0]), "sync osc div");
         chk(16'(loop_cfg.prediv), 16'h0001 << c[1:0], "prediv");
         chk(16'(sync_cfg.prediv), 16'h0001 << c[1:0], "sync prediv");
         chk(16'({loop_cfg.ref_select, loop_cfg.ref_valid}), {11'h000, c, f_ref_ok(c, 1'b0) == 16'h1}, "ref");
         chk(16'({sync_cfg.ref_select, sync_cfg.ref_valid}), {11'h000, c, f_ref_ok(c, 1'b1) == 16'h1}, "sref");
         chk(16'(loop_cfg.gain), f_gain(c), "gain");
         chk(16'(sync_cfg.gain), f_gain(c), "sync gain");
         chk(16'(sync_cfg.narrow_bw), 16'(c[0]), "bandwidth");
      end
      end_test("decode");
      r = xs();
      wr(loop_ctrl_pkg::OFS_LOOP_FRAC_DENOMINATOR, r);
      wr(loop_ctrl_pkg::OFS_SYNC_INTEGER, ~r);
      wr(loop_ctrl_pkg::OFS_SYNC_FRAC_NUMERATOR, r ^ 16'h5A5A);
      wr(loop_ctrl_pkg::OFS_SYNC_FRAC_DENOMINATOR, r + 16'h0001);
      @(posedge clk);
      reg_wr <= 1'b1;
      clk_en <= 1'b0;
      reg_addr <= loop_ctrl_pkg::OFS_LOOP_FRAC_DENOMINATOR;
      reg_wdata <= ~r;
      @(posedge clk);
      reg_wr <= 1'b0;
      clk_en <= 1'b1;
      settle();
      chk(loop_cfg.frac_den, r, "den");
      chk(16'(sync_cfg.int_mult), ~r & 16'h03FF, "sync int");
      chk(sync_cfg.frac_num, r ^ 16'h5A5A, "sync num");
      chk(sync_cfg.frac_den, r + 16'h0001, "sync den");
      wr(loop_ctrl_pkg::OFS_SYNC_ENABLE_CTRL, 16'h0001);
      end_test("ratios");
      r = xs();
      a2 = xs();
      n2 = xs();
      wr(loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE, r & 16'h03FF);
      wr(loop_ctrl_pkg::OFS_LOOP_FRAC_NUMERATOR, ~r);
      wr(loop_ctrl_pkg::OFS_LOOP_ENABLE_CTRL, 16'h0001);
      settle();
      chk(16'(loop_cfg.int_mult), r & 16'h03FF, "int direct");
      chk(loop_cfg.frac_num, ~r, "num direct");
      chk(16'({loop_cfg.enable, loop_running, sync_cfg.enable}), 16'h0007, "enables");
      wr(loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE, a2 & 16'h03FF);
      wr(loop_ctrl_pkg::OFS_LOOP_FRAC_NUMERATOR, n2);
      settle();
      chk(16'(loop_cfg.int_mult), r & 16'h03FF, "int held");
      chk(loop_cfg.frac_num, ~r, "num held");
      rd(loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE, a2 & 16'h03FF);
      wr(loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE, (a2 & 16'h03FF) | 16'h8000);
      settle();
      chk(16'(loop_cfg.int_mult), a2 & 16'h03FF, "int commit");
      chk(loop_cfg.frac_num, n2, "num commit");
      rd(loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE, a2 & 16'h03FF);
      wr(loop_ctrl_pkg::OFS_LOOP_FRAC_NUMERATOR, ~n2);
      wr(loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE, a2 & 16'h03FF);
      settle();
      chk(loop_cfg.frac_num, n2, "zero update");
      wr(loop_ctrl_pkg::OFS_LOOP_ENABLE_CTRL, 16'h0000);
      wr(loop_ctrl_pkg::OFS_LOOP_INTEGER_AND_UPDATE, (r & 16'h03FF) | 16'h8000);
      settle();
      chk(16'({loop_cfg.enable, loop_running}), 16'h0000, "disabled");
      chk(16'(loop_cfg.int_mult), r & 16'h03FF, "int idle");
      end_test("update");
      for (int i = 0; i < 14; i++) begin
         r = xs();
         wr(map_addr[i], r);
         rd(map_addr[i], r & map_mask[i]);
      end
      end_test("readback");
      do_reset();
      check_defaults();
      end_test("second reset");
      summarize();
   end
endmodule
